// File: hw/lmc_pkg.sv
package lmc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int TXD_REL_NS    = 10000;    // 10 us release time
    localparam int LW_REARM_NS   = 10000;    // 10 us wake rearm time
    localparam int DOM_TO_MS     = 20;       // 20 ms dominant timeout
    // Least times round up to whole cycles
    localparam int TXD_REL_CYC   =
        (TXD_REL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LW_REARM_CYC  =
        (LW_REARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DOM_TO_CYC    =
        (DOM_TO_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 20;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        LMC_UNPOWERED = 4'h1,
        LMC_FAILSAFE  = 4'h2,
        LMC_NORMAL    = 4'h4,
        LMC_SLEEP     = 4'h8
    } lmc_mode_t;

    typedef enum logic [1:0] {
        LMC_SRC_NONE  = 2'h0,
        LMC_SRC_BUS   = 2'h1,
        LMC_SRC_LOCAL = 2'h2,
        LMC_SRC_UV    = 2'h3
    } lmc_src_t;

    typedef struct packed {
        logic poweron;
        logic loss;
        logic undervoltage;
        logic recovered;
    } lmc_supply_t;

    localparam lmc_supply_t SUPPLY_RST = '{default: 1'b0};
    localparam logic [1:0]  SYNC_RST   = 2'h0;

endpackage

// File: hw/lmc_mode_ctrl.sv
`timescale 1ns/1ps

// Function
// - Normal mode enables transmit and receive paths, regulator enable on.
// - Enable falling edge requests sleep; transmit path is disabled.
// - Sleep turns regulator enable off and disconnects bus termination.
// - Sleep entry ignores bus level and local wake input level.
// - With transmit stuck low, sleep is accepted after dominant timeout.
// - Power-up and wake enter fail-safe, regulator on unless undervoltage, transceiver off.
// - Fail-safe lasts until enable is high with no undervoltage, then normal mode.
// - Fail-safe reports source on transmit and receive pins.
// - Fail-safe entered by undervoltage from normal accepts enable fall.
// - Sleep: pre-wake, fall, long dominant, rise raise remote wake.
// - Remote wake: fail-safe, regulator on, termination on, receive low.
// - Local wake input low past filter time wakes into fail-safe.
// - Local wake shown as transmit low, receive high.
// - Local wake rearms only after input high over 10 us.
// - Wake source indications clear once normal mode is entered.
// - Power-on flag moves unpowered to fail-safe, regulator on unless undervoltage.
// - Undervoltage in sleep blocks wake; of the supply flags only loss changes mode.
// - Undervoltage in normal moves to fail-safe, transceiver off.
// - Supply loss moves to unpowered, regulator enable off.
// - Transmit low past 20 ms forces recessive until released high.
// - Transmit low at normal entry blocks driver until high 10 us.
// - Normal mode receive pin mirrors the bus level.
module lmc_mode_ctrl #(
    parameter int DOM_TO_CYC   = lmc_pkg::DOM_TO_CYC,
    parameter int BUS_WAKE_CYC = 2000,
    parameter int LW_WAKE_CYC  = 2000
) (
    // Clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    // Microcontroller pins
    input  wire logic              en_i,
    input  wire logic              txd_i,
    output logic                   txd_o,
    output logic                   txd_oe_o,
    output logic                   rxd_o,
    output logic                   rxd_oe_o,
    // Bus side
    input  wire logic              lin_rx_i,
    input  wire logic              lin_prewake_i,
    output logic                   lin_dominant_o,
    output logic                   term_en_o,
    // Local wake and supply flags
    input  wire logic              local_wake_input_i,
    input  wire lmc_pkg::lmc_supply_t supply_i,
    // Regulator and status
    output logic                   regulator_enable_out_o,
    output lmc_pkg::lmc_mode_t     mode_o,
    // Wake source event stream
    output logic                   evt_valid_o,
    output lmc_pkg::lmc_src_t      evt_src_o,
    input  wire logic              evt_ready_i
);
    import lmc_pkg::*;
    localparam logic [CNT_W-1:0] REL_LIM  = CNT_W'(TXD_REL_CYC);
    localparam logic [CNT_W-1:0] RARM_LIM = CNT_W'(LW_REARM_CYC);
    localparam logic [CNT_W-1:0] DOM_LIM  = CNT_W'(DOM_TO_CYC);
    localparam logic [CNT_W-1:0] BW_LIM   = CNT_W'(BUS_WAKE_CYC);
    localparam logic [CNT_W-1:0] LW_LIM   = CNT_W'(LW_WAKE_CYC);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Saturating count while run is high, cleared otherwise
    function automatic logic [CNT_W-1:0] cnt_step(
        input logic [CNT_W-1:0] cnt,
        input logic             run
    );
        return run ? ((&cnt) ? cnt : cnt + CNT_W'(1)) : CNT_ZERO;
    endfunction

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic [1:0]   en_sy_ff, txd_sy_ff, rx_sy_ff, pw_sy_ff, lw_sy_ff;
    lmc_supply_t  sup_m_ff, sup_ff;
    logic         en_q_ff, rx_q_ff;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            en_sy_ff  <= SYNC_RST;
            txd_sy_ff <= SYNC_RST;
            rx_sy_ff  <= SYNC_RST;
            pw_sy_ff  <= SYNC_RST;
            lw_sy_ff  <= SYNC_RST;
            sup_m_ff  <= SUPPLY_RST;
            sup_ff    <= SUPPLY_RST;
            en_q_ff   <= 1'b0;
            rx_q_ff   <= 1'b0;
        end else begin
            en_sy_ff  <= {en_sy_ff[0], en_i};
            txd_sy_ff <= {txd_sy_ff[0], txd_i};
            rx_sy_ff  <= {rx_sy_ff[0], lin_rx_i};
            pw_sy_ff  <= {pw_sy_ff[0], lin_prewake_i};
            lw_sy_ff  <= {lw_sy_ff[0], local_wake_input_i};
            sup_m_ff  <= supply_i;
            sup_ff    <= sup_m_ff;
            en_q_ff   <= en_sy_ff[1];
            rx_q_ff   <= rx_sy_ff[1];
        end
    end
    wire en_s    = en_sy_ff[1];
    wire txd_s   = txd_sy_ff[1];
    wire rx_s    = rx_sy_ff[1];
    wire pw_s    = pw_sy_ff[1];
    wire lw_s    = lw_sy_ff[1];
    wire en_fall = en_q_ff & ~en_s;
    wire rx_fall = rx_q_ff & ~rx_s;
    wire rx_rise = ~rx_q_ff & rx_s;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    lmc_mode_t        mode_ff, nxt_mode;
    lmc_src_t         src_ff, nxt_src;
    logic             from_uv_ff, nxt_from_uv;
    logic             uv_ff, nxt_uv;
    logic [CNT_W-1:0] dom_cnt_ff, rel_cnt_ff, bw_cnt_ff;
    logic [CNT_W-1:0] lw_cnt_ff, rarm_cnt_ff;
    logic             dom_to_ff, nxt_dom_to;
    logic             lock_ff, nxt_lock;
    logic             bw_arm_ff, nxt_bw_arm;
    logic             lw_ok_ff, nxt_lw_ok;
    wire in_fs    = (mode_ff == LMC_FAILSAFE);
    wire in_norm  = (mode_ff == LMC_NORMAL);
    wire in_sleep = (mode_ff == LMC_SLEEP);
    wire in_unpow = (mode_ff == LMC_UNPOWERED);

    // ------------------------------------------------------------
    // Transmit timers
    // ------------------------------------------------------------
    wire txd_released = (rel_cnt_ff >= REL_LIM);
    wire dom_expired  = (dom_cnt_ff >= DOM_LIM);
    wire lock_set     = (nxt_mode == LMC_NORMAL) & ~in_norm & ~txd_s;
    // Both clear only after transmit has stayed high for the release time
    assign nxt_dom_to = ~txd_released
                      & (dom_to_ff | (in_norm & dom_expired));
    assign nxt_lock   = lock_set | (lock_ff & ~txd_released);

    // ------------------------------------------------------------
    // Wake detection
    // ------------------------------------------------------------
    // Undervoltage in sleep blocks both wake paths
    wire wake_gate = in_sleep & ~uv_ff;
    wire bus_wake  = wake_gate & bw_arm_ff & rx_rise
                   & (bw_cnt_ff > BW_LIM);
    wire lw_wake   = wake_gate & lw_ok_ff & ~lw_s
                   & (lw_cnt_ff > LW_LIM);
    wire lw_rearm  = lw_s & (rarm_cnt_ff > RARM_LIM);
    assign nxt_bw_arm = in_sleep & ~rx_rise
                      & (bw_arm_ff | (rx_fall & pw_s));
    assign nxt_lw_ok  = lw_rearm
                      | (lw_ok_ff & ~lw_wake & (in_sleep | lw_s));

    // ------------------------------------------------------------
    // Supply latch with hysteresis
    // ------------------------------------------------------------
    assign nxt_uv = sup_ff.undervoltage | (uv_ff & ~sup_ff.recovered);

    // ------------------------------------------------------------
    // Mode sequencer
    // ------------------------------------------------------------
    // Sleep needs transmit high, unless the dominant timeout has fired
    wire sleep_ok = txd_s | dom_to_ff;
    always_comb begin
        nxt_mode    = mode_ff;
        nxt_src     = src_ff;
        nxt_from_uv = from_uv_ff;
        if (sup_ff.loss) begin
            nxt_mode    = LMC_UNPOWERED;
            nxt_src     = LMC_SRC_NONE;
            nxt_from_uv = 1'b0;
        end else begin
            case (mode_ff)
                LMC_UNPOWERED: begin
                    if (sup_ff.poweron) begin
                        nxt_mode = LMC_FAILSAFE;
                    end
                end
                LMC_NORMAL: begin
                    if (uv_ff) begin
                        nxt_mode    = LMC_FAILSAFE;
                        nxt_src     = LMC_SRC_UV;
                        nxt_from_uv = 1'b1;
                    end else if (!en_s && sleep_ok) begin
                        nxt_mode = LMC_SLEEP;
                    end
                end
                LMC_FAILSAFE: begin
                    if (from_uv_ff && en_fall) begin
                        nxt_mode    = LMC_SLEEP;
                        nxt_from_uv = 1'b0;
                    end else if (en_s && !uv_ff) begin
                        nxt_mode    = LMC_NORMAL;
                        nxt_src     = LMC_SRC_NONE;
                        nxt_from_uv = 1'b0;
                    end
                end
                LMC_SLEEP: begin
                    if (bus_wake) begin
                        nxt_mode = LMC_FAILSAFE;
                        nxt_src  = LMC_SRC_BUS;
                    end else if (lw_wake) begin
                        nxt_mode = LMC_FAILSAFE;
                        nxt_src  = LMC_SRC_LOCAL;
                    end
                end
                default: begin
                    nxt_mode = LMC_UNPOWERED;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------
    logic nxt_txd_oe, nxt_rxd_oe, nxt_lin_dom, nxt_term, nxt_reg;
    wire  fs_next   = (nxt_mode == LMC_FAILSAFE);
    wire  norm_next = (nxt_mode == LMC_NORMAL);
    always_comb begin
        // Open-drain style: enable high pulls the pin low
        nxt_txd_oe = fs_next & (nxt_src == LMC_SRC_BUS ||
                                nxt_src == LMC_SRC_LOCAL);
        nxt_rxd_oe = 1'b0;
        if (fs_next) begin
            nxt_rxd_oe = (nxt_src == LMC_SRC_BUS) ||
                         (nxt_src == LMC_SRC_UV);
        end else if (norm_next) begin
            nxt_rxd_oe = ~rx_s;
        end
        nxt_lin_dom = norm_next & ~txd_s & ~nxt_dom_to
                    & ~nxt_lock;
        nxt_term    = fs_next | norm_next;
        // Fail-safe keeps the regulator off while undervoltage holds
        nxt_reg     = norm_next | (fs_next & ~nxt_uv);
    end

    // ------------------------------------------------------------
    // Wake source event buffer
    // ------------------------------------------------------------
    // A pending event waits here until the skid slot frees; a newer
    // event overwrites it, so a long stall can lose a source.
    logic     pend_v_ff, nxt_pend_v;
    lmc_src_t pend_ff, nxt_pend;
    logic     head_v_ff, nxt_head_v, skid_v_ff, nxt_skid_v;
    lmc_src_t head_ff, nxt_head, skid_ff, nxt_skid;
    wire new_evt = (nxt_src != src_ff) && (nxt_src != LMC_SRC_NONE);
    wire push    = pend_v_ff & ~skid_v_ff;
    wire pop     = head_v_ff & evt_ready_i;
    always_comb begin
        nxt_pend_v = pend_v_ff & ~push;
        nxt_pend   = pend_ff;
        if (new_evt) begin
            nxt_pend_v = 1'b1;
            nxt_pend   = nxt_src;
        end
        nxt_head   = head_ff;
        nxt_head_v = head_v_ff;
        nxt_skid   = skid_ff;
        nxt_skid_v = skid_v_ff;
        if (!head_v_ff || pop) begin
            if (skid_v_ff) begin
                nxt_head   = skid_ff;
                nxt_head_v = 1'b1;
                nxt_skid   = pend_ff;
                nxt_skid_v = push;
            end else begin
                nxt_head   = pend_ff;
                nxt_head_v = push;
            end
        end else if (push) begin
            nxt_skid   = pend_ff;
            nxt_skid_v = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_ff    <= LMC_UNPOWERED;
            src_ff     <= LMC_SRC_NONE;
            from_uv_ff <= 1'b0;
            uv_ff      <= 1'b0;
            dom_to_ff  <= 1'b0;
            lock_ff    <= 1'b0;
            bw_arm_ff  <= 1'b0;
            lw_ok_ff   <= 1'b0;
        end else begin
            mode_ff    <= nxt_mode;
            src_ff     <= nxt_src;
            from_uv_ff <= nxt_from_uv;
            uv_ff      <= nxt_uv;
            dom_to_ff  <= nxt_dom_to;
            lock_ff    <= nxt_lock;
            bw_arm_ff  <= nxt_bw_arm;
            lw_ok_ff   <= nxt_lw_ok;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dom_cnt_ff  <= CNT_ZERO;
            rel_cnt_ff  <= CNT_ZERO;
            bw_cnt_ff   <= CNT_ZERO;
            lw_cnt_ff   <= CNT_ZERO;
            rarm_cnt_ff <= CNT_ZERO;
        end else begin
            dom_cnt_ff  <= cnt_step(dom_cnt_ff, in_norm & ~txd_s);
            rel_cnt_ff  <= cnt_step(rel_cnt_ff, txd_s);
            bw_cnt_ff   <= cnt_step(bw_cnt_ff, bw_arm_ff & ~rx_s);
            lw_cnt_ff   <= cnt_step(lw_cnt_ff, in_sleep & ~lw_s);
            rarm_cnt_ff <= cnt_step(rarm_cnt_ff, lw_s);
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_v_ff <= 1'b0;
            pend_ff   <= LMC_SRC_NONE;
            head_v_ff <= 1'b0;
            head_ff   <= LMC_SRC_NONE;
            skid_v_ff <= 1'b0;
            skid_ff   <= LMC_SRC_NONE;
        end else begin
            pend_v_ff <= nxt_pend_v;
            pend_ff   <= nxt_pend;
            head_v_ff <= nxt_head_v;
            head_ff   <= nxt_head;
            skid_v_ff <= nxt_skid_v;
            skid_ff   <= nxt_skid;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            txd_o                  <= 1'b0;
            rxd_o                  <= 1'b0;
            txd_oe_o               <= 1'b0;
            rxd_oe_o               <= 1'b0;
            lin_dominant_o         <= 1'b0;
            term_en_o              <= 1'b0;
            regulator_enable_out_o <= 1'b0;
            mode_o                 <= LMC_UNPOWERED;
        end else begin
            // Pin data is always low; only the enables move
            txd_o                  <= 1'b0;
            rxd_o                  <= 1'b0;
            txd_oe_o               <= nxt_txd_oe;
            rxd_oe_o               <= nxt_rxd_oe;
            lin_dominant_o         <= nxt_lin_dom;
            term_en_o              <= nxt_term;
            regulator_enable_out_o <= nxt_reg;
            mode_o                 <= nxt_mode;
        end
    end

    assign evt_valid_o = head_v_ff;
    assign evt_src_o   = head_ff;

endmodule

// File: sim/lmc_mode_checker.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Mode and pin checker
// ------------------------------------------------------------
module lmc_mode_checker
    import lmc_pkg::*;
#(
    parameter int DOM_TO_CYC = lmc_pkg::DOM_TO_CYC
) (
    input wire logic                 sys_clk_i,
    input wire logic                 rst_i,
    input wire logic                 en_i,
    input wire logic                 txd_i,
    input wire logic                 txd_o,
    input wire logic                 txd_oe_o,
    input wire logic                 rxd_o,
    input wire logic                 rxd_oe_o,
    input wire logic                 lin_rx_i,
    input wire logic                 lin_prewake_i,
    input wire logic                 lin_dominant_o,
    input wire logic                 term_en_o,
    input wire logic                 local_wake_input_i,
    input wire lmc_pkg::lmc_supply_t supply_i,
    input wire logic                 regulator_enable_out_o,
    input wire lmc_pkg::lmc_mode_t   mode_o,
    input wire logic                 evt_valid_o,
    input wire lmc_pkg::lmc_src_t    evt_src_o,
    input wire logic                 evt_ready_i
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // Counts low transmit cycles; a few extra cycles cover the sync delay
    int lo_cnt_ff;
    int nxt_lo_cnt;
    assign nxt_lo_cnt = txd_i ? 0 : lo_cnt_ff + 1;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lo_cnt_ff <= 0;
        end else begin
            lo_cnt_ff <= nxt_lo_cnt;
        end
    end

    a_normal_reg_on: assert property (
        mode_o == LMC_NORMAL |-> regulator_enable_out_o)
        else $error("Regulator off in normal mode");
    a_sleep_all_off: assert property (
        mode_o == LMC_SLEEP |-> !regulator_enable_out_o && !term_en_o)
        else $error("Regulator or termination on in sleep");
    a_unpow_all_off: assert property (
        mode_o == LMC_UNPOWERED |->
        !regulator_enable_out_o && !txd_oe_o && !rxd_oe_o)
        else $error("Outputs active while unpowered");
    a_drv_only_norm: assert property (
        lin_dominant_o |-> mode_o == LMC_NORMAL)
        else $error("Bus driven outside normal mode");
    a_loss_to_unpow: assert property (
        supply_i.loss [*3] |=> mode_o == LMC_UNPOWERED)
        else $error("Supply loss did not reach unpowered");
    a_src_clr_norm: assert property (
        mode_o == LMC_NORMAL |-> !txd_oe_o)
        else $error("Wake source still shown in normal mode");
    a_rx_mirror: assert property (
        (mode_o == LMC_NORMAL && $stable(lin_rx_i)) [*4]
        |-> rxd_oe_o == !lin_rx_i)
        else $error("Receive pin does not follow the bus");
    a_dom_timeout: assert property (
        lo_cnt_ff > DOM_TO_CYC + 4 |-> !lin_dominant_o)
        else $error("Bus held dominant past the timeout");
    a_evt_hold: assert property (
        evt_valid_o && !evt_ready_i |=> evt_valid_o && $stable(evt_src_o))
        else $error("Event dropped while receiver stalled");
endmodule

// File: sim/lmc_far_end.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Far side: bus wire, remote node and event receiver
// ------------------------------------------------------------
module lmc_far_end (
    // Clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    // Bus
    input  wire logic              lin_dominant_i,
    input  wire logic              remote_dom_i,
    output logic                   lin_rx_o,
    output logic                   lin_prewake_o,
    // Event receiver
    input  wire logic              stall_i,
    input  wire logic              evt_valid_i,
    input  wire lmc_pkg::lmc_src_t evt_src_i,
    output logic                   evt_ready_o
);
    import lmc_pkg::*;
    lmc_src_t log [$];
    // Wired-AND bus: pull-up keeps it recessive unless someone pulls low
    assign lin_rx_o      = !(lin_dominant_i || remote_dom_i);
    assign lin_prewake_o = !lin_rx_o;
    assign evt_ready_o   = !stall_i;
    always @(posedge sys_clk_i) begin
        if (!rst_i && evt_valid_i && evt_ready_o) begin
            log.push_back(evt_src_i);
        end
    end
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Mode controller bench
// ------------------------------------------------------------
module tb;
    import lmc_pkg::*;
    localparam int DOM_CYC = 500;
    // Stim bits: en txd wake remote_dom poweron uv recovered loss
    // Exp bits: mode[3:0] regulator term txd_oe rxd_oe
    typedef struct packed {
        logic [7:0]  stim;
        logic [15:0] cyc;
        logic [7:0]  exp;
    } lmc_row_t;
    logic        sys_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic [7:0]  stim      = 8'h60;
    logic        stall     = 1'b1;
    int          bad_count = 0;
    int          compares  = 0;
    logic        txd_o, txd_oe_o, rxd_o, rxd_oe_o, txd_wire;
    logic        lin_rx, lin_prewake, lin_dominant_o, term_en_o;
    logic        regulator_enable_out_o, evt_valid_o, evt_ready;
    lmc_mode_t   mode_o;
    lmc_src_t    evt_src_o;
    lmc_supply_t supply;
    lmc_src_t    exp_src [5] = '{LMC_SRC_BUS, LMC_SRC_LOCAL, LMC_SRC_LOCAL,
                                 LMC_SRC_UV, LMC_SRC_BUS};
    lmc_row_t    rows [24] = '{
        '{8'h68, 250, 8'h2c}, '{8'he8, 6, 8'h4c},
        '{8'h68, 6, 8'h80}, '{8'h78, 30, 8'h80},
        '{8'h68, 6, 8'h2f}, '{8'he8, 6, 8'h4c},
        '{8'h68, 6, 8'h80}, '{8'h48, 30, 8'h2e},
        '{8'hc8, 6, 8'h4c}, '{8'h48, 30, 8'h80},
        '{8'h68, 6, 8'h80}, '{8'h48, 30, 8'h80},
        '{8'h68, 250, 8'h80}, '{8'h48, 30, 8'h2e},
        '{8'he8, 6, 8'h4c}, '{8'hec, 6, 8'h25},
        '{8'h6c, 6, 8'h80}, '{8'h7c, 30, 8'h80},
        '{8'h6c, 6, 8'h80}, '{8'h6a, 6, 8'h80},
        '{8'h7a, 30, 8'h80}, '{8'h6a, 6, 8'h2f},
        '{8'h69, 6, 8'h10}, '{8'h68, 6, 8'h2c}};
    // The device pulls the shared transmit line low when it signals
    assign txd_wire = txd_oe_o ? txd_o : stim[6];
    assign supply   = lmc_supply_t'({stim[3], stim[0], stim[2], stim[1]});
    always #25 sys_clk_i = ~sys_clk_i;

    lmc_mode_ctrl #(.DOM_TO_CYC(DOM_CYC), .BUS_WAKE_CYC(20),
                    .LW_WAKE_CYC(20)) dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .en_i(stim[7]),
        .txd_i(txd_wire), .txd_o(txd_o), .txd_oe_o(txd_oe_o),
        .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .lin_rx_i(lin_rx),
        .lin_prewake_i(lin_prewake), .lin_dominant_o(lin_dominant_o),
        .term_en_o(term_en_o), .local_wake_input_i(stim[5]),
        .supply_i(supply), .regulator_enable_out_o(regulator_enable_out_o),
        .mode_o(mode_o), .evt_valid_o(evt_valid_o), .evt_src_o(evt_src_o),
        .evt_ready_i(evt_ready));
    lmc_far_end u_far (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .lin_dominant_i(lin_dominant_o), .remote_dom_i(stim[4]),
        .lin_rx_o(lin_rx), .lin_prewake_o(lin_prewake), .stall_i(stall),
        .evt_valid_i(evt_valid_o), .evt_src_i(evt_src_o),
        .evt_ready_o(evt_ready));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic step(input logic [7:0] v, input int n);
        @(negedge sys_clk_i);
        stim = v;
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic print_verdict;
        if (bad_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs about 1600 cycles
    initial begin
        #(50 * 8000);
        bad_count++;
        print_verdict();
    end

    initial begin
        repeat (5) @(negedge sys_clk_i);
        rst_i = 1'b0;
        foreach (rows[i]) begin
            // Receiver stalls over the first two wakes to fill the buffer
            stall = (i < 8) ? 1'b1 : 1'b0;
            step(rows[i].stim, int'(rows[i].cyc));
            check({mode_o, regulator_enable_out_o, term_en_o, txd_oe_o,
                   rxd_oe_o}, rows[i].exp);
            if (i == 7) begin
                check({7'h0, evt_valid_o}, 8'h01);
            end
        end
        step(8'ha8, 6);
        check({mode_o, 2'h0, rxd_oe_o, lin_dominant_o}, 8'h40);
        step(8'he8, 210);
        step(8'ha8, 6);
        check({mode_o, 2'h0, rxd_oe_o, lin_dominant_o}, 8'h43);
        step(8'ha8, DOM_CYC + 10);
        check({mode_o, 2'h0, rxd_oe_o, lin_dominant_o}, 8'h40);
        step(8'h28, 6);
        check({mode_o, 4'h0}, 8'h80);
        step(8'h68, 6);
        check(8'(u_far.log.size()), 8'h05);
        check({6'h0, txd_o, rxd_o}, 8'h00);
        for (int k = 0; k < 5; k++) begin
            check({6'h0, u_far.log[k]}, {6'h0, exp_src[k]});
        end
        rst_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        check({mode_o, regulator_enable_out_o, term_en_o, txd_oe_o,
               rxd_oe_o}, 8'h10);
        print_verdict();
    end
endmodule

bind lmc_mode_ctrl lmc_mode_checker #(.DOM_TO_CYC(DOM_TO_CYC)) u_chk (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .en_i(en_i), .txd_i(txd_i),
    .txd_o(txd_o), .txd_oe_o(txd_oe_o), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o),
    .lin_rx_i(lin_rx_i), .lin_prewake_i(lin_prewake_i),
    .lin_dominant_o(lin_dominant_o), .term_en_o(term_en_o),
    .local_wake_input_i(local_wake_input_i), .supply_i(supply_i),
    .regulator_enable_out_o(regulator_enable_out_o), .mode_o(mode_o),
    .evt_valid_o(evt_valid_o), .evt_src_o(evt_src_o),
    .evt_ready_i(evt_ready_i));
